// *** hw/fsmd_pkg.sv ***
// constants, display modes and glyph font for the fault status matrix display
package fsmd_pkg;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_HZ          = 10_000_000;
  localparam int FLASH_HALF_MS   = 500;
  localparam int FLASH_HALF_CYC  = FLASH_HALF_MS * (CLK_HZ / 1000);

  // ***************************************************
  // matrix geometry and numbering
  // ***************************************************
  localparam int MATRIX_COLS     = 5;
  localparam int MATRIX_ROWS     = 7;
  localparam int MATRIX_DOTS     = MATRIX_COLS * MATRIX_ROWS;
  localparam int QUEUE_DEPTH     = 4;
  localparam logic [4:0] NUM_MIN = 5'h01;
  localparam logic [4:0] NUM_MAX = 5'h14;
  localparam logic [4:0] NUM_TEN = 5'h0a;

  // ***************************************************
  // glyph codes
  // ***************************************************
  localparam logic [3:0] GLYPH_A      = 4'ha;
  localparam logic [3:0] GLYPH_B      = 4'hb;
  localparam logic [3:0] GLYPH_C      = 4'hc;
  localparam logic [3:0] GLYPH_CIRCLE = 4'hd;
  localparam logic [3:0] GLYPH_ZERO   = 4'h0;

  // queued clearable fault kinds
  localparam logic QK_USER    = 1'b1;
  localparam logic QK_MONITOR = 1'b0;

  typedef enum logic [2:0] {
    FSMD_M_FAIL_FLASH = 3'b000,
    FSMD_M_ALL_ON     = 3'b001,
    FSMD_M_INIT       = 3'b010,
    FSMD_M_INIT_ERR   = 3'b011,
    FSMD_M_COMM       = 3'b100,
    FSMD_M_QUEUED     = 3'b101,
    FSMD_M_NUMBER     = 3'b110
  } fsmd_mode_e;

  // rows top to bottom, bit 4 of a row is the leftmost column
  function automatic logic [MATRIX_DOTS-1:0] fsmd_glyph(input logic [3:0] code);
    logic [MATRIX_DOTS-1:0] g;
    g = '0;
    case (code)
      4'h0:    g = {5'h0e, 5'h11, 5'h13, 5'h15, 5'h19, 5'h11, 5'h0e};
      4'h1:    g = {5'h04, 5'h0c, 5'h04, 5'h04, 5'h04, 5'h04, 5'h0e};
      4'h2:    g = {5'h0e, 5'h11, 5'h01, 5'h02, 5'h04, 5'h08, 5'h1f};
      4'h3:    g = {5'h1f, 5'h02, 5'h04, 5'h02, 5'h01, 5'h11, 5'h0e};
      4'h4:    g = {5'h02, 5'h06, 5'h0a, 5'h12, 5'h1f, 5'h02, 5'h02};
      4'h5:    g = {5'h1f, 5'h10, 5'h1e, 5'h01, 5'h01, 5'h11, 5'h0e};
      4'h6:    g = {5'h06, 5'h08, 5'h10, 5'h1e, 5'h11, 5'h11, 5'h0e};
      4'h7:    g = {5'h1f, 5'h01, 5'h02, 5'h04, 5'h08, 5'h08, 5'h08};
      4'h8:    g = {5'h0e, 5'h11, 5'h11, 5'h0e, 5'h11, 5'h11, 5'h0e};
      4'h9:    g = {5'h0e, 5'h11, 5'h11, 5'h0f, 5'h01, 5'h02, 5'h0c};
      4'ha:    g = {5'h0e, 5'h11, 5'h11, 5'h1f, 5'h11, 5'h11, 5'h11};
      4'hb:    g = {5'h10, 5'h10, 5'h16, 5'h19, 5'h11, 5'h11, 5'h1e};
      4'hc:    g = {5'h0e, 5'h11, 5'h10, 5'h10, 5'h10, 5'h11, 5'h0e};
      4'hd:    g = {5'h00, 5'h0e, 5'h11, 5'h11, 5'h11, 5'h0e, 5'h00};
      default: g = '0;
    endcase
    return g;
  endfunction

endpackage

// *** hw/fsmd_display.sv ***
// fault status matrix display: priority, clearable fault queue, flashing, glyph output
// Functional notes
// - normal operation shows configured module number 1 to 20, not clearable
// - an active user, monitoring or communication fault replaces the number with a category letter
// - flashing alternates the pattern slowly with a fully dark matrix
// - user diagnostic event shows A, program runs, clearable by acknowledge
// - startup: program halted, all dots off, circle and phase numbers, not clearable
// - module failure flashes all 35 dots, program stopped, not clearable
// - partial power or main logic failure lights all dots steadily, not clearable
// - acknowledge clears clearable fault, then the next pending fault shows
// - button level is also offered as a digital input
// - output drives a five column by seven row dot matrix
// - monitoring errors show b, program runs, clearable by acknowledge
// - init error shows 0, flashing if local, steady if remote, not clearable
// - communication error shows C, program runs, not clearable
module fsmd_display #(
  parameter int FLASH_CYC = fsmd_pkg::FLASH_HALF_CYC,
  parameter int DEPTH     = fsmd_pkg::QUEUE_DEPTH
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [4:0]  module_number,
  input  wire logic        init_active,
  input  wire logic [3:0]  init_phase,
  input  wire logic        module_fail,
  input  wire logic        steady_fail,
  input  wire logic        init_error,
  input  wire logic        init_error_local,
  input  wire logic        comm_error,
  input  wire logic        user_fault_event,
  input  wire logic        monitor_fault_event,
  input  wire logic        acknowledge_button,
  output logic [fsmd_pkg::MATRIX_DOTS-1:0] dots,
  output logic             program_halt,
  output logic             button_input_block
);

  localparam int QW = $clog2(DEPTH);
  localparam logic [QW:0] DEPTH_C = (QW + 1)'(DEPTH);
  localparam logic [31:0] FLASH_LAST = 32'(FLASH_CYC - 1);

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic [31:0]                      flash_cnt;
    logic                             flash_on;
    logic                             btn_prev;
    logic                             button_level;
    logic [DEPTH-1:0]                 q;
    logic [QW-1:0]                    head;
    logic [QW:0]                      count;
    logic [fsmd_pkg::MATRIX_DOTS-1:0] dots;
    logic                             halt;
  } fsmd_state_s;

  fsmd_state_s         st;
  fsmd_state_s         next_st;
  fsmd_pkg::fsmd_mode_e mode;
  logic                ack_edge;
  logic                pop;

  // ***************************************************
  // next state
  // ***************************************************
  always_comb
  begin
    logic [QW-1:0] hd;
    logic [QW:0]   cnt;
    logic [4:0]    units;
    logic [3:0]    tens;
    hd    = st.head;
    cnt   = st.count;
    units = module_number;
    tens  = 4'h0;
    next_st = st;

    // slow blink clock shared by every flashing pattern
    if (st.flash_cnt >= FLASH_LAST)
    begin
      next_st.flash_cnt = '0;
      next_st.flash_on  = ~st.flash_on;
    end
    else
    begin
      next_st.flash_cnt = st.flash_cnt + 32'h1;
    end

    next_st.btn_prev     = acknowledge_button;
    next_st.button_level = acknowledge_button;

    // whole-matrix failures outrank everything else
    if (module_fail)
      mode = fsmd_pkg::FSMD_M_FAIL_FLASH;
    else if (steady_fail)
      mode = fsmd_pkg::FSMD_M_ALL_ON;
    else if (init_active)
      mode = fsmd_pkg::FSMD_M_INIT;
    else if (init_error)
      mode = fsmd_pkg::FSMD_M_INIT_ERR;
    else if (comm_error)
      mode = fsmd_pkg::FSMD_M_COMM;
    else if (st.count != '0)
      mode = fsmd_pkg::FSMD_M_QUEUED;
    else
      mode = fsmd_pkg::FSMD_M_NUMBER;

    // only the fault actually on display may be acknowledged
    ack_edge = acknowledge_button & ~st.btn_prev;
    pop      = ack_edge && (mode == fsmd_pkg::FSMD_M_QUEUED);
    if (pop)
    begin
      hd  = hd + QW'(1);
      cnt = cnt - (QW + 1)'(1);
    end
    // arrivals in the pop cycle are kept: set wins over clear
    if (user_fault_event && (cnt < DEPTH_C))
    begin
      next_st.q[hd + cnt[QW-1:0]] = fsmd_pkg::QK_USER;
      cnt = cnt + (QW + 1)'(1);
    end
    if (monitor_fault_event && (cnt < DEPTH_C))
    begin
      next_st.q[hd + cnt[QW-1:0]] = fsmd_pkg::QK_MONITOR;
      cnt = cnt + (QW + 1)'(1);
    end
    next_st.head  = hd;
    next_st.count = cnt;

    // two-digit numbers alternate tens and units at the blink rate
    if (module_number >= fsmd_pkg::NUM_MAX)
    begin
      tens  = 4'h2;
      units = module_number - fsmd_pkg::NUM_MAX;
    end
    else if (module_number >= fsmd_pkg::NUM_TEN)
    begin
      tens  = 4'h1;
      units = module_number - fsmd_pkg::NUM_TEN;
    end

    case (mode)
      fsmd_pkg::FSMD_M_FAIL_FLASH:
        next_st.dots = st.flash_on ? '1 : '0;
      fsmd_pkg::FSMD_M_ALL_ON:
        next_st.dots = '1;
      fsmd_pkg::FSMD_M_INIT:
        if (init_phase == 4'h0)
          next_st.dots = '0;
        else if (st.flash_on)
          next_st.dots = fsmd_pkg::fsmd_glyph(fsmd_pkg::GLYPH_CIRCLE);
        else
          next_st.dots = fsmd_pkg::fsmd_glyph(init_phase);
      fsmd_pkg::FSMD_M_INIT_ERR:
        if (init_error_local && !st.flash_on)
          next_st.dots = '0;
        else
          next_st.dots = fsmd_pkg::fsmd_glyph(fsmd_pkg::GLYPH_ZERO);
      fsmd_pkg::FSMD_M_COMM:
        next_st.dots = fsmd_pkg::fsmd_glyph(fsmd_pkg::GLYPH_C);
      fsmd_pkg::FSMD_M_QUEUED:
        next_st.dots = fsmd_pkg::fsmd_glyph(st.q[st.head] == fsmd_pkg::QK_USER
                                            ? fsmd_pkg::GLYPH_A : fsmd_pkg::GLYPH_B);
      fsmd_pkg::FSMD_M_NUMBER:
        if (tens != 4'h0 && !st.flash_on)
          next_st.dots = fsmd_pkg::fsmd_glyph(tens);
        else
          next_st.dots = fsmd_pkg::fsmd_glyph(units[3:0]);
      default:
        next_st.dots = '1;
    endcase

    next_st.halt = module_fail | steady_fail | init_active | init_error;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign dots               = st.dots;
  assign program_halt       = st.halt;
  assign button_input_block = st.button_level;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic hi_prio;
  assign hi_prio = module_fail | steady_fail | init_active | init_error | comm_error;

  a_fail_flash_all: assert property (module_fail && st.flash_on |=> dots == '1)
    else $error("module failure did not light all dots in lit phase");
  a_fail_flash_dark: assert property (module_fail && !st.flash_on |=> dots == '0)
    else $error("module failure did not darken matrix in dark phase");
  a_steady_all_on: assert property (!module_fail && steady_fail [*2] |=> dots == '1)
    else $error("steady failure did not keep all dots lit");
  a_init_dark: assert property (!module_fail && !steady_fail && init_active
                                && init_phase == 4'h0 |=> dots == '0)
    else $error("startup phase zero did not blank matrix");
  a_halt_follows: assert property ($rose(hi_prio & ~comm_error) |=> program_halt)
    else $error("program halt not raised for halting state");
  a_button_mirror: assert property (acknowledge_button |=> button_input_block)
    else $error("button level not mirrored");
  a_ack_pops: assert property (pop && !user_fault_event && !monitor_fault_event
                               |=> st.count == $past(st.count) - (QW + 1)'(1))
    else $error("acknowledge did not remove displayed fault");
  a_comm_letter: assert property (comm_error && !module_fail && !steady_fail && !init_active
                                  && !init_error |=> dots == fsmd_pkg::fsmd_glyph(fsmd_pkg::GLYPH_C))
    else $error("communication error letter missing");
  a_user_letter: assert property (!hi_prio && st.count == '0 && user_fault_event
                                  ##1 !hi_prio |=> dots == fsmd_pkg::fsmd_glyph(fsmd_pkg::GLYPH_A))
    else $error("user fault letter missing");
  a_number_shown: assert property (!hi_prio && st.count == '0 && module_number >= fsmd_pkg::NUM_MIN
                                   && module_number < fsmd_pkg::NUM_TEN
                                   |=> dots == fsmd_pkg::fsmd_glyph($past(module_number[3:0])))
    else $error("module number not displayed");

  c_fail_flash: cover property (module_fail && st.flash_on ##1 module_fail);
  c_ack_clear: cover property (pop ##1 st.count != '0);
  c_queue_full: cover property (st.count == DEPTH_C);
  c_number: cover property (!hi_prio && st.count == '0 && module_number == fsmd_pkg::NUM_MAX);

endmodule

// *** verif/fsmd_fault_source.sv ***
// fault source and operator button model facing the status display
module fsmd_fault_source
(
  input  wire logic sys_clk,
  output logic      user_fault_event,
  output logic      monitor_fault_event,
  output logic      acknowledge_button
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    user_fault_event    = 1'b0;
    monitor_fault_event = 1'b0;
    acknowledge_button  = 1'b0;
  end

  // event pulses held for cyc edges, called just after a rising edge
  // back-to-back events stay high instead of dropping and rising in one time step
  task automatic raise(input logic u, input logic m, input int cyc);
    user_fault_event    = u;
    monitor_fault_event = m;
    repeat (cyc) @(posedge sys_clk);
    #1;
    user_fault_event    = 1'b0;
    monitor_fault_event = 1'b0;
  endtask

  // slow operators hold the button for several cycles
  task automatic press(input int hold);
    acknowledge_button = 1'b1;
    repeat (hold) @(posedge sys_clk);
    #1;
    acknowledge_button = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic level(input logic v);
    acknowledge_button = v;
  endtask
endmodule

// *** verif/testbench.sv ***
// self-checking bench for the fault status matrix display
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FL = 8;
  localparam logic [34:0] ONES = '1;
  localparam logic [34:0] G_A = {5'h0e, 5'h11, 5'h11, 5'h1f, 5'h11, 5'h11, 5'h11};
  localparam logic [34:0] G_B = {5'h10, 5'h10, 5'h16, 5'h19, 5'h11, 5'h11, 5'h1e};
  localparam logic [34:0] G_C = {5'h0e, 5'h11, 5'h10, 5'h10, 5'h10, 5'h11, 5'h0e};
  localparam logic [34:0] G_0 = {5'h0e, 5'h11, 5'h13, 5'h15, 5'h19, 5'h11, 5'h0e};
  localparam logic [34:0] G_7 = {5'h1f, 5'h01, 5'h02, 5'h04, 5'h08, 5'h08, 5'h08};
  logic        sys_clk, reset, init_active, module_fail, steady_fail;
  logic        init_error, init_error_local, comm_error, probe;
  logic        user_fault_event, monitor_fault_event, acknowledge_button;
  logic        program_halt, button_input_block;
  logic [4:0]  module_number;
  logic [3:0]  init_phase;
  logic [34:0] dots;
  logic [37:0] notes[$];
  logic [37:0] n;
  logic [35:0] obs;
  logic [31:0] seed;
  int          errors, n_checks;
  logic        loc;
  int          tn, un;

  fsmd_display #(.FLASH_CYC(FL)) i_fsmd_display (.sys_clk, .reset, .module_number,
    .init_active, .init_phase, .module_fail, .steady_fail, .init_error, .init_error_local,
    .comm_error, .user_fault_event, .monitor_fault_event, .acknowledge_button, .dots,
    .program_halt, .button_input_block);
  fsmd_fault_source i_fsmd_fault_source (.sys_clk, .user_fault_event,
    .monitor_fault_event, .acknowledge_button);

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // expected digit and circle patterns, top row first
  function automatic logic [34:0] dig(input logic [3:0] d);
    logic [34:0] g;
    g = '0;
    case (d)
      4'h0:    g = {5'h0e, 5'h11, 5'h13, 5'h15, 5'h19, 5'h11, 5'h0e};
      4'h1:    g = {5'h04, 5'h0c, 5'h04, 5'h04, 5'h04, 5'h04, 5'h0e};
      4'h2:    g = {5'h0e, 5'h11, 5'h01, 5'h02, 5'h04, 5'h08, 5'h1f};
      4'h3:    g = {5'h1f, 5'h02, 5'h04, 5'h02, 5'h01, 5'h11, 5'h0e};
      4'h4:    g = {5'h02, 5'h06, 5'h0a, 5'h12, 5'h1f, 5'h02, 5'h02};
      4'h5:    g = {5'h1f, 5'h10, 5'h1e, 5'h01, 5'h01, 5'h11, 5'h0e};
      4'h6:    g = {5'h06, 5'h08, 5'h10, 5'h1e, 5'h11, 5'h11, 5'h0e};
      4'h7:    g = {5'h1f, 5'h01, 5'h02, 5'h04, 5'h08, 5'h08, 5'h08};
      4'h8:    g = {5'h0e, 5'h11, 5'h11, 5'h0e, 5'h11, 5'h11, 5'h0e};
      4'h9:    g = {5'h0e, 5'h11, 5'h11, 5'h0f, 5'h01, 5'h02, 5'h0c};
      4'hd:    g = {5'h00, 5'h0e, 5'h11, 5'h11, 5'h11, 5'h0e, 5'h00};
      default: g = '0;
    endcase
    return g;
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  // mode 0 halt and dots, 1 dots only, 2 button echo
  task automatic chk(input logic [1:0] m, input logic [35:0] v);
    notes.push_back({m, v});
    probe = 1'b1;
    step(1);
    probe = 1'b0;
  endtask

  // sync to a dark to lit change, then the dark pattern must follow FL cycles later
  task automatic flash(input logic [1:0] m, input logic [35:0] lit, input logic [34:0] dark);
    int          k;
    logic [34:0] last;
    k = 0;
    last = ~dark;
    while (!(last === dark && dots !== dark) && k < 4 * FL)
    begin
      last = dots;
      step(1);
      k++;
    end
    if (k == 4 * FL)
    begin
      errors++;
      end_of_test();
    end
    chk(m, lit);
    step(FL - 1);
    chk(m, {lit[35], dark});
  endtask

  always @(negedge sys_clk)
  begin
    if (probe === 1'b1)
    begin
      n = notes.pop_front();
      obs = {program_halt, dots};
      if (n[37:36] == 2'h1)
      begin
        obs[35] = 1'b0;
        n[35] = 1'b0;
      end
      if (n[37:36] == 2'h2)
        obs = {35'h0, button_input_block};
      n_checks++;
      if (obs !== n[35:0])
      begin
        errors++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, n[35:0], obs);
      end
    end
  end

  initial
  begin
    {errors, n_checks} = '0;
    {probe, init_active, init_phase, module_fail, steady_fail} = '0;
    {init_error, init_error_local, comm_error} = '0;
    seed = 32'h3656285b;
    module_number = 5'h07;
    reset = 1'b1;
    step(1);
    chk(2'h0, 36'h0);
    reset = 1'b0;
    step(2);
    chk(2'h0, {1'b0, G_7});
    i_fsmd_fault_source.press(1);
    step(2);
    chk(2'h0, {1'b0, G_7});
    i_fsmd_fault_source.raise(1'b1, 1'b1, 1);
    step(3);
    chk(2'h0, {1'b0, G_A});
    i_fsmd_fault_source.press(1);
    step(2);
    chk(2'h0, {1'b0, G_B});
    i_fsmd_fault_source.press(3);
    step(2);
    chk(2'h0, {1'b0, G_7});
    comm_error = 1'b1;
    i_fsmd_fault_source.raise(1'b1, 1'b0, 1);
    step(3);
    chk(2'h0, {1'b0, G_C});
    i_fsmd_fault_source.press(1);
    step(2);
    chk(2'h0, {1'b0, G_C});
    comm_error = 1'b0;
    i_fsmd_fault_source.raise(1'b1, 1'b0, 4);
    repeat (4)
    begin
      step(2);
      chk(2'h0, {1'b0, G_A});
      i_fsmd_fault_source.press(1);
    end
    step(2);
    chk(2'h0, {1'b0, G_7});
    init_error = 1'b1;
    i_fsmd_fault_source.press(1);
    seed = xs(seed);
    loc = seed[2];
    repeat (2)
    begin
      init_error_local = loc;
      step(2);
      if (loc)
        flash(2'h1, {1'b0, G_0}, 35'h0);
      else
        chk(2'h1, {1'b0, G_0});
      loc = ~loc;
    end
    {init_error, init_error_local, init_active} = 3'h1;
    step(2);
    chk(2'h0, {1'b1, 35'h0});
    seed = xs(seed);
    init_phase = 4'h1 + 4'(seed[7:0] % 9);
    flash(2'h0, {1'b1, dig(4'hd)}, dig(init_phase));
    {init_active, steady_fail, comm_error} = 3'h3;
    i_fsmd_fault_source.raise(1'b1, 1'b0, 1);
    i_fsmd_fault_source.press(1);
    step(2);
    chk(2'h0, {1'b1, ONES});
    module_fail = 1'b1;
    flash(2'h0, {1'b1, ONES}, 35'h0);
    {module_fail, steady_fail, comm_error} = 3'h0;
    step(2);
    chk(2'h0, {1'b0, G_A});
    i_fsmd_fault_source.press(1);
    repeat (16)
    begin
      seed = xs(seed);
      i_fsmd_fault_source.level(seed[0]);
      step(1);
      chk(2'h2, {35'h0, seed[0]});
    end
    chk(2'h0, {1'b0, G_7});
    // two-digit numbers show tens in the dark phase and units in the lit phase
    repeat (6)
    begin
      seed = xs(seed);
      module_number = 5'h01 + 5'(seed[7:0] % 20);
      tn = int'(module_number) / 10;
      un = int'(module_number) % 10;
      step(2);
      if (tn == 0 || tn == un)
        chk(2'h0, {1'b0, dig(4'(un))});
      else
        flash(2'h0, {1'b0, dig(4'(un))}, dig(4'(tn)));
    end
    end_of_test();
  end
endmodule
